//--- hdl/mus_pkg.sv
// Package for the motion unit scaling block: parameter addresses, factory values, timing.
package mus_pkg;

    // ------------------------------------------------------------------
    // Parameter addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] MUS_ADDR_POS_DEN = 16'h060E;
    localparam logic [15:0] MUS_ADDR_POS_NUM = 16'h0610;
    localparam logic [15:0] MUS_ADDR_VEL_DEN = 16'h0642;
    localparam logic [15:0] MUS_ADDR_VEL_NUM = 16'h0644;
    localparam logic [15:0] MUS_ADDR_RMP_DEN = 16'h0660;
    localparam logic [15:0] MUS_ADDR_RMP_NUM = 16'h0662;

    // ------------------------------------------------------------------
    // Factory values and limits
    // ------------------------------------------------------------------
    localparam logic [31:0] MUS_POS_DEN_RST = 32'h0000_4000;
    localparam logic [31:0] MUS_POS_NUM_RST = 32'h0000_0001;
    localparam logic [31:0] MUS_VEL_DEN_RST = 32'h0000_0001;
    localparam logic [31:0] MUS_VEL_NUM_RST = 32'h0000_0001;
    localparam logic [31:0] MUS_RMP_DEN_RST = 32'h0000_0001;
    localparam logic [31:0] MUS_RMP_NUM_RST = 32'h0000_0001;
    localparam logic [31:0] MUS_VAL_MIN     = 32'h0000_0001;
    localparam logic [31:0] MUS_VAL_MAX     = 32'h7FFF_FFFF;
    // Ratio below 1/131072 means den > num * 131072, i.e. num shifted by 17.
    localparam int          MUS_SMALL_SHIFT = 17;
    // Movement range in position user units, applied only when the position ratio is below 1/131072.
    localparam logic signed [31:0] MUS_RANGE_MIN = -32'sd268435456;
    localparam logic signed [31:0] MUS_RANGE_MAX = 32'sd268435455;

    // ------------------------------------------------------------------
    // Divider timing: quotient bits per conversion
    // ------------------------------------------------------------------
    localparam int          MUS_DIV_STEPS   = 64;

    typedef enum logic [1:0] {
        MUS_Q_POS = 2'b00,
        MUS_Q_VEL = 2'b01,
        MUS_Q_RMP = 2'b10
    } mus_qty_t;

endpackage

//--- hdl/mus_div_if.sv
// Interface between the scaling controller and the multiply-divide engine.
`timescale 1ns/1ps
interface mus_div_if;
    logic              start;
    logic signed [31:0] value;
    logic [31:0]       mulBy;
    logic [31:0]       divBy;
    logic              busy;
    logic              done;
    logic signed [63:0] result;

    modport ctrl (output start, output value, output mulBy, output divBy,
                  input busy, input done, input result);
    modport eng  (input start, input value, input mulBy, input divBy,
                  output busy, output done, output result);
endinterface

//--- hdl/mus_muldiv.sv
// One-cycle signed multiply then sequential restoring divide: result = value * mulBy / divBy.
`timescale 1ns/1ps
module mus_muldiv
    import mus_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    mus_div_if.eng    dv
);
    logic [63:0] remReg,  remNext;
    logic [63:0] quoReg,  quoNext;
    logic [31:0] divReg,  divNext;
    logic        negReg,  negNext;
    logic [6:0]  cntReg,  cntNext;
    logic        busyReg, busyNext;
    logic        doneReg, doneNext;
    logic signed [63:0] resReg, resNext;
    logic [31:0] magIn;
    logic [64:0] trial;

    always_comb begin
        remNext  = remReg;
        quoNext  = quoReg;
        divNext  = divReg;
        negNext  = negReg;
        cntNext  = cntReg;
        busyNext = busyReg;
        doneNext = 1'b0;
        resNext  = resReg;
        magIn    = dv.value[31] ? 32'(-dv.value) : dv.value;
        trial    = {remReg, quoReg[63]} - {33'h0_0000_0000, divReg};
        if (!busyReg && dv.start) begin
            // The product fits in 63 bits since magIn is at most 2^31 and mulBy is below 2^32.
            quoNext  = 64'(magIn) * 64'(dv.mulBy);
            remNext  = 64'h0;
            divNext  = dv.divBy;
            negNext  = dv.value[31];
            cntNext  = 7'(MUS_DIV_STEPS);
            busyNext = 1'b1;
        end else if (busyReg) begin
            if (!trial[64]) begin
                remNext = trial[63:0];
                quoNext = {quoReg[62:0], 1'b1};
            end else begin
                remNext = {remReg[62:0], quoReg[63]};
                quoNext = {quoReg[62:0], 1'b0};
            end
            cntNext = cntReg - 7'h01;
            if (cntReg == 7'h01) begin
                busyNext = 1'b0;
                doneNext = 1'b1;
                resNext  = negReg ? -$signed(quoNext) : $signed(quoNext);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            remReg  <= 64'h0;
            quoReg  <= 64'h0;
            divReg  <= 32'h0000_0001;
            negReg  <= 1'b0;
            cntReg  <= 7'h00;
            busyReg <= 1'b0;
            doneReg <= 1'b0;
            resReg  <= 64'sh0;
        end else begin
            remReg  <= remNext;
            quoReg  <= quoNext;
            divReg  <= divNext;
            negReg  <= negNext;
            cntReg  <= cntNext;
            busyReg <= busyNext;
            doneReg <= doneNext;
            resReg  <= resNext;
        end
    end

    assign dv.busy   = busyReg;
    assign dv.done   = doneReg;
    assign dv.result = resReg;
endmodule

//--- hdl/mus_scaling.sv
// Motion unit scaling: scaling parameters, write guard and unit conversion.
`timescale 1ns/1ps
module mus_scaling
    import mus_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Parameter access.
    input  wire logic               parWrite,
    input  wire logic               parRead,
    input  wire logic [15:0]        parAddr,
    input  wire logic [31:0]        parWdata,
    output logic      [31:0]        parRdata,
    output logic                    parAck,
    output logic                    parRefused,
    // Persistent store: values restored after reset when valid.
    input  wire logic               storeValid,
    input  wire logic [31:0]        storePosNum,
    input  wire logic [31:0]        storePosDen,
    input  wire logic [31:0]        storeVelNum,
    input  wire logic [31:0]        storeVelDen,
    input  wire logic [31:0]        storeRmpNum,
    input  wire logic [31:0]        storeRmpDen,
    input  wire logic               powerStageOn,
    // Conversion request.
    input  wire logic               convReq,
    input  wire logic [1:0]         convQty,
    input  wire logic               convToUser,
    input  wire logic signed [31:0] convIn,
    output logic                    convReady,
    output logic                    convDone,
    output logic signed [31:0]      convOut,
    output logic                    convClipped,
    output logic                    scaleReady
);
    // ------------------------------------------------------------------
    // Parameter registers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MUS_S_LOAD = 2'b00,
        MUS_S_IDLE = 2'b01,
        MUS_S_CONV = 2'b10
    } mus_state_t;

    mus_state_t  stateReg, stateNext;
    logic [31:0] posNumReg, posNumNext, posDenReg, posDenNext;
    logic [31:0] velNumReg, velNumNext, velDenReg, velDenNext;
    logic [31:0] rmpNumReg, rmpNumNext, rmpDenReg, rmpDenNext;
    // Committed ratios used by conversions.
    logic [31:0] cPosNumReg, cPosNumNext, cPosDenReg, cPosDenNext;
    logic [31:0] cVelNumReg, cVelNumNext, cVelDenReg, cVelDenNext;
    logic [31:0] cRmpNumReg, cRmpNumNext, cRmpDenReg, cRmpDenNext;
    logic [31:0] rdataReg, rdataNext;
    logic        ackReg, ackNext, refReg, refNext;
    logic signed [31:0] outReg, outNext;
    logic        doneReg, doneNext, clipReg, clipNext;
    logic        startReg, startNext;
    logic signed [31:0] valReg, valNext;
    logic [31:0] mulReg, mulNext, divReg, divNext;
    logic        clampReg, clampNext;
    logic        inRange, wrOk;
    logic [31:0] selNum, selDen;
    logic signed [63:0] res;

    mus_div_if dv();

    mus_muldiv u_muldiv (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .dv       (dv.eng)
    );

    assign dv.start = startReg;
    assign dv.value = valReg;
    assign dv.mulBy = mulReg;
    assign dv.divBy = divReg;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        stateNext   = stateReg;
        posNumNext  = posNumReg;
        posDenNext  = posDenReg;
        velNumNext  = velNumReg;
        velDenNext  = velDenReg;
        rmpNumNext  = rmpNumReg;
        rmpDenNext  = rmpDenReg;
        cPosNumNext = cPosNumReg;
        cPosDenNext = cPosDenReg;
        cVelNumNext = cVelNumReg;
        cVelDenNext = cVelDenReg;
        cRmpNumNext = cRmpNumReg;
        cRmpDenNext = cRmpDenReg;
        rdataNext   = rdataReg;
        ackNext     = 1'b0;
        refNext     = 1'b0;
        outNext     = outReg;
        doneNext    = 1'b0;
        clipNext    = clipReg;
        startNext   = 1'b0;
        valNext     = valReg;
        mulNext     = mulReg;
        divNext     = divReg;
        clampNext   = clampReg;
        res         = dv.result;
        inRange     = (parWdata >= MUS_VAL_MIN) && (parWdata <= MUS_VAL_MAX);
        wrOk        = inRange && !powerStageOn;
        selNum      = 32'h0000_0001;
        selDen      = 32'h0000_0001;

        case (convQty)
            MUS_Q_POS: begin
                selNum = cPosNumReg;
                selDen = cPosDenReg;
            end
            MUS_Q_VEL: begin
                selNum = cVelNumReg;
                selDen = cVelDenReg;
            end
            default: begin
                selNum = cRmpNumReg;
                selDen = cRmpDenReg;
            end
        endcase

        case (stateReg)
            MUS_S_LOAD: begin
                // Restore and commit every ratio before any conversion runs.
                if (storeValid) begin
                    posNumNext = storePosNum;
                    posDenNext = storePosDen;
                    velNumNext = storeVelNum;
                    velDenNext = storeVelDen;
                    rmpNumNext = storeRmpNum;
                    rmpDenNext = storeRmpDen;
                end
                cPosNumNext = posNumNext;
                cPosDenNext = posDenNext;
                cVelNumNext = velNumNext;
                cVelDenNext = velDenNext;
                cRmpNumNext = rmpNumNext;
                cRmpDenNext = rmpDenNext;
                stateNext   = MUS_S_IDLE;
            end
            MUS_S_IDLE: begin
                if (parWrite) begin
                    ackNext = 1'b1;
                    refNext = !wrOk;
                    if (wrOk) begin
                        case (parAddr)
                            MUS_ADDR_POS_DEN: posDenNext = parWdata;
                            MUS_ADDR_VEL_DEN: velDenNext = parWdata;
                            MUS_ADDR_RMP_DEN: rmpDenNext = parWdata;
                            MUS_ADDR_POS_NUM: begin
                                posNumNext  = parWdata;
                                cPosNumNext = parWdata;
                                cPosDenNext = posDenReg;
                            end
                            MUS_ADDR_VEL_NUM: begin
                                velNumNext  = parWdata;
                                cVelNumNext = parWdata;
                                cVelDenNext = velDenReg;
                            end
                            MUS_ADDR_RMP_NUM: begin
                                rmpNumNext  = parWdata;
                                cRmpNumNext = parWdata;
                                cRmpDenNext = rmpDenReg;
                            end
                            default: refNext = 1'b1;
                        endcase
                    end
                end else if (parRead) begin
                    ackNext = 1'b1;
                    case (parAddr)
                        MUS_ADDR_POS_DEN: rdataNext = posDenReg;
                        MUS_ADDR_POS_NUM: rdataNext = posNumReg;
                        MUS_ADDR_VEL_DEN: rdataNext = velDenReg;
                        MUS_ADDR_VEL_NUM: rdataNext = velNumReg;
                        MUS_ADDR_RMP_DEN: rdataNext = rmpDenReg;
                        MUS_ADDR_RMP_NUM: rdataNext = rmpNumReg;
                        default: begin
                            rdataNext = 32'h0000_0000;
                            refNext   = 1'b1;
                        end
                    endcase
                end else if (convReq) begin
                    // Internal = user * num / den; user = internal * den / num.
                    mulNext   = convToUser ? selDen : selNum;
                    divNext   = convToUser ? selNum : selDen;
                    clampNext = (convQty == MUS_Q_POS) && !convToUser &&
                                ({32'h0, cPosDenReg} >
                                 ({32'h0, cPosNumReg} << MUS_SMALL_SHIFT)) &&
                                ((convIn > MUS_RANGE_MAX) || (convIn < MUS_RANGE_MIN));
                    // The bound is applied in user units before scaling, so the scaled
                    // result is the internal value of the range limit itself.
                    valNext   = convIn;
                    if (clampNext && (convIn > MUS_RANGE_MAX)) begin
                        valNext = MUS_RANGE_MAX;
                    end else if (clampNext) begin
                        valNext = MUS_RANGE_MIN;
                    end
                    startNext = 1'b1;
                    stateNext = MUS_S_CONV;
                end
            end
            MUS_S_CONV: begin
                if (dv.done) begin
                    doneNext  = 1'b1;
                    stateNext = MUS_S_IDLE;
                    clipNext  = clampReg;
                    if (res > 64'sh0000_0000_7FFF_FFFF) begin
                        outNext  = 32'sh7FFF_FFFF;
                        clipNext = 1'b1;
                    end else if (res < -64'sh0000_0000_8000_0000) begin
                        outNext  = -32'sh8000_0000;
                        clipNext = 1'b1;
                    end else begin
                        outNext  = res[31:0];
                    end
                end
            end
            default: stateNext = MUS_S_LOAD;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg   <= MUS_S_LOAD;
            posNumReg  <= MUS_POS_NUM_RST;
            posDenReg  <= MUS_POS_DEN_RST;
            velNumReg  <= MUS_VEL_NUM_RST;
            velDenReg  <= MUS_VEL_DEN_RST;
            rmpNumReg  <= MUS_RMP_NUM_RST;
            rmpDenReg  <= MUS_RMP_DEN_RST;
            cPosNumReg <= MUS_POS_NUM_RST;
            cPosDenReg <= MUS_POS_DEN_RST;
            cVelNumReg <= MUS_VEL_NUM_RST;
            cVelDenReg <= MUS_VEL_DEN_RST;
            cRmpNumReg <= MUS_RMP_NUM_RST;
            cRmpDenReg <= MUS_RMP_DEN_RST;
            rdataReg   <= 32'h0000_0000;
            ackReg     <= 1'b0;
            refReg     <= 1'b0;
            outReg     <= 32'sh0;
            doneReg    <= 1'b0;
            clipReg    <= 1'b0;
            startReg   <= 1'b0;
            valReg     <= 32'sh0;
            mulReg     <= 32'h0000_0001;
            divReg     <= 32'h0000_0001;
            clampReg   <= 1'b0;
        end else begin
            stateReg   <= stateNext;
            posNumReg  <= posNumNext;
            posDenReg  <= posDenNext;
            velNumReg  <= velNumNext;
            velDenReg  <= velDenNext;
            rmpNumReg  <= rmpNumNext;
            rmpDenReg  <= rmpDenNext;
            cPosNumReg <= cPosNumNext;
            cPosDenReg <= cPosDenNext;
            cVelNumReg <= cVelNumNext;
            cVelDenReg <= cVelDenNext;
            cRmpNumReg <= cRmpNumNext;
            cRmpDenReg <= cRmpDenNext;
            rdataReg   <= rdataNext;
            ackReg     <= ackNext;
            refReg     <= refNext;
            outReg     <= outNext;
            doneReg    <= doneNext;
            clipReg    <= clipNext;
            startReg   <= startNext;
            valReg     <= valNext;
            mulReg     <= mulNext;
            divReg     <= divNext;
            clampReg   <= clampNext;
        end
    end

    assign parRdata    = rdataReg;
    assign parAck      = ackReg;
    assign parRefused  = refReg;
    assign convOut     = outReg;
    assign convDone    = doneReg;
    assign convClipped = clipReg;
    assign scaleReady  = (stateReg != MUS_S_LOAD);
    assign convReady   = (stateReg == MUS_S_IDLE) && !parWrite && !parRead;
endmodule

//--- tb/mus_scaling_chk.sv
// Concurrent checks on the ports of the motion unit scaling block.
`timescale 1ns/1ps
module mus_scaling_chk (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        parWrite,
    input wire logic        parRead,
    input wire logic [31:0] parWdata,
    input wire logic        parAck,
    input wire logic        parRefused,
    input wire logic        powerStageOn,
    input wire logic        convReq,
    input wire logic        convReady,
    input wire logic        convDone,
    input wire logic        scaleReady
);
    logic convBusy;
    logic idle;

    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    // Requests made while a conversion runs are ignored, so the checks on
    // parameter answers must know when the engine is busy.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            convBusy <= 1'b0;
        end else if (convReq && convReady) begin
            convBusy <= 1'b1;
        end else if (convDone) begin
            convBusy <= 1'b0;
        end
    end
    assign idle = scaleReady && !convBusy;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_access_ack: assert property ((parWrite || parRead) && idle |=> parAck)
        else $error("access taken without answer");
    a_no_spurious: assert property (!(parWrite || parRead) |=> !parAck)
        else $error("answer without access");
    a_refuse_ack: assert property (parRefused |-> parAck)
        else $error("refusal without answer");
    a_power_refuse: assert property (parWrite && powerStageOn && idle |=> parRefused)
        else $error("write accepted with power stage on");
    a_range_refuse: assert property (parWrite && idle && (parWdata == 32'h0 || parWdata[31])
        |=> parRefused)
        else $error("out of range value accepted");
    a_conv_latency: assert property (convReq && convReady |-> ##67 convDone)
        else $error("conversion result not on time");
    a_conv_quiet: assert property (convReq && convReady |=> (!convDone) [*8])
        else $error("conversion result too early");
    a_busy_block: assert property (convBusy && !convDone |-> !convReady)
        else $error("ready while converting");
    a_ready_hold: assert property (scaleReady |=> scaleReady)
        else $error("scaling ready dropped");
endmodule

bind mus_scaling mus_scaling_chk u_mus_scaling_chk (
    .core_clk(core_clk), .rst_n(rst_n), .parWrite(parWrite), .parRead(parRead),
    .parWdata(parWdata), .parAck(parAck), .parRefused(parRefused),
    .powerStageOn(powerStageOn), .convReq(convReq), .convReady(convReady),
    .convDone(convDone), .scaleReady(scaleReady)
);

//--- tb/mus_scaling_tb_top.sv
// Self-checking testbench of the motion unit scaling block.
`timescale 1ns/1ps
module mus_scaling_tb_top;
    import mus_pkg::*;
    logic               coreClk;
    logic               rstN;
    logic               parWrite;
    logic               parRead;
    logic        [15:0] parAddr;
    logic        [31:0] parWdata;
    logic        [31:0] parRdata;
    logic               parAck;
    logic               parRefused;
    logic               storeValid;
    logic        [31:0] storeVal [6];
    logic               powerStageOn;
    logic               convReq;
    logic        [1:0]  convQty;
    logic               convToUser;
    logic signed [31:0] convIn;
    logic               convReady;
    logic               convDone;
    logic signed [31:0] convOut;
    logic               convClipped;
    logic               scaleReady;
    int                 nFail;
    int                 checkCount;
    int                 cycles;

    mus_scaling u_mus_scaling (
        .core_clk(coreClk), .rst_n(rstN), .parWrite(parWrite), .parRead(parRead),
        .parAddr(parAddr), .parWdata(parWdata), .parRdata(parRdata), .parAck(parAck),
        .parRefused(parRefused), .storeValid(storeValid), .storePosNum(storeVal[0]),
        .storePosDen(storeVal[1]), .storeVelNum(storeVal[2]), .storeVelDen(storeVal[3]),
        .storeRmpNum(storeVal[4]), .storeRmpDen(storeVal[5]), .powerStageOn(powerStageOn),
        .convReq(convReq), .convQty(convQty), .convToUser(convToUser), .convIn(convIn),
        .convReady(convReady), .convDone(convDone), .convOut(convOut),
        .convClipped(convClipped), .scaleReady(scaleReady)
    );

    // ------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------
    always #25 coreClk = ~coreClk;

    // The whole run needs about 1500 cycles; hangs are cut well above that.
    always @(posedge coreClk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            nFail = nFail + 1;
            completeRun();
        end
    end

    task automatic completeRun();
        if (nFail == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount = checkCount + 1;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h", $time, what, got);
            nFail = nFail + 1;
        end
    endtask

    task automatic doReset();
        @(negedge coreClk);
        rstN = 1'b0;
        repeat (16) @(negedge coreClk);
        rstN = 1'b1;
        repeat (2) @(negedge coreClk);
        ck({31'h0, scaleReady}, 32'h1, "ready after load");
    endtask

    // One write (w=1) or read; refusal is judged on writes, data on reads.
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic r, input logic [31:0] e);
        @(negedge coreClk);
        parWrite = w;
        parRead = !w;
        parAddr = a;
        parWdata = d;
        @(negedge coreClk);
        parWrite = 1'b0;
        parRead = 1'b0;
        ck({31'h0, parAck}, 32'h1, "ack");
        if (w) ck({31'h0, parRefused}, {31'h0, r}, "refused");
        else ck(parRdata, e, "read data");
    endtask

    task automatic cv(input logic [1:0] q, input logic u, input logic [31:0] x,
                      input logic [31:0] e, input logic c);
        int k;
        @(negedge coreClk);
        ck({31'h0, convReady}, 32'h1, "conv ready");
        convQty = q;
        convToUser = u;
        convIn = x;
        convReq = 1'b1;
        @(negedge coreClk);
        convReq = 1'b0;
        k = 0;
        while (convDone !== 1'b1 && k < 100) begin
            @(negedge coreClk);
            k = k + 1;
        end
        ck({31'h0, convDone}, 32'h1, "conv done");
        ck(convOut, e, "conv result");
        ck({31'h0, convClipped}, {31'h0, c}, "clip flag");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic tFactory();
        acc(0, MUS_ADDR_POS_DEN, 32'h0, 0, 32'h0000_4000);
        acc(0, MUS_ADDR_POS_NUM, 32'h0, 0, 32'h1);
        acc(0, MUS_ADDR_VEL_DEN, 32'h0, 0, 32'h1);
        acc(0, MUS_ADDR_VEL_NUM, 32'h0, 0, 32'h1);
        acc(0, MUS_ADDR_RMP_DEN, 32'h0, 0, 32'h1);
        acc(0, MUS_ADDR_RMP_NUM, 32'h0, 0, 32'h1);
        cv(MUS_Q_POS, 0, 32'h0000_C000, 32'h3, 0);
        cv(MUS_Q_VEL, 1, 32'hFFFF_FB2E, 32'hFFFF_FB2E, 0);
        cv(MUS_Q_RMP, 0, 32'h4D, 32'h4D, 0);
    endtask

    task automatic tStage();
        acc(1, MUS_ADDR_POS_DEN, 32'h2, 0, 32'h0);
        cv(MUS_Q_POS, 0, 32'h0000_C000, 32'h3, 0);
        acc(0, MUS_ADDR_POS_DEN, 32'h0, 0, 32'h2);
        acc(1, MUS_ADDR_POS_NUM, 32'h1, 0, 32'h0);
        cv(MUS_Q_POS, 0, 32'h0000_C000, 32'h0000_6000, 0);
        cv(MUS_Q_POS, 1, 32'h64, 32'hC8, 0);
    endtask

    task automatic tVelRamp();
        acc(1, MUS_ADDR_VEL_DEN, 32'h4, 0, 32'h0);
        acc(1, MUS_ADDR_VEL_NUM, 32'h2, 0, 32'h0);
        cv(MUS_Q_VEL, 0, 32'h64, 32'h32, 0);
        cv(MUS_Q_VEL, 1, 32'h32, 32'h64, 0);
        acc(1, MUS_ADDR_RMP_DEN, 32'h3, 0, 32'h0);
        acc(1, MUS_ADDR_RMP_NUM, 32'h6, 0, 32'h0);
        cv(MUS_Q_RMP, 0, 32'hFFFF_FFF9, 32'hFFFF_FFF2, 0);
        cv(MUS_Q_RMP, 1, 32'hFFFF_FFF9, 32'hFFFF_FFFD, 0);
    endtask

    task automatic tRefuse();
        @(negedge coreClk);
        powerStageOn = 1'b1;
        acc(1, MUS_ADDR_VEL_NUM, 32'h5, 1, 32'h0);
        acc(1, MUS_ADDR_VEL_DEN, 32'h5, 1, 32'h0);
        @(negedge coreClk);
        powerStageOn = 1'b0;
        acc(0, MUS_ADDR_VEL_NUM, 32'h0, 0, 32'h2);
        acc(1, MUS_ADDR_RMP_DEN, 32'h0, 1, 32'h0);
        acc(1, MUS_ADDR_RMP_DEN, 32'h8000_0000, 1, 32'h0);
        acc(1, MUS_ADDR_RMP_DEN, 32'hFFFF_FFFF, 1, 32'h0);
        acc(1, MUS_ADDR_RMP_DEN, 32'h7FFF_FFFF, 0, 32'h0);
        acc(0, MUS_ADDR_RMP_DEN, 32'h0, 0, 32'h7FFF_FFFF);
        acc(1, 16'h0600, 32'h1, 1, 32'h0);
        acc(0, 16'h0600, 32'h0, 0, 32'h0);
        cv(MUS_Q_RMP, 0, 32'hA, 32'h14, 0);
        cv(MUS_Q_RMP, 0, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 1);
        cv(2'h3, 0, 32'h8000_0000, 32'h8000_0000, 1);
    endtask

    task automatic tSmall();
        acc(1, MUS_ADDR_POS_DEN, 32'h0002_0000, 0, 32'h0);
        acc(1, MUS_ADDR_POS_NUM, 32'h1, 0, 32'h0);
        cv(MUS_Q_POS, 0, 32'h1000_0000, 32'h800, 0);
        acc(1, MUS_ADDR_POS_DEN, 32'h0002_0001, 0, 32'h0);
        acc(1, MUS_ADDR_POS_NUM, 32'h1, 0, 32'h0);
        cv(MUS_Q_POS, 0, 32'h1000_0000, 32'h7FF, 1);
        cv(MUS_Q_POS, 0, 32'hE000_0000, 32'hFFFF_F801, 1);
        cv(MUS_Q_POS, 0, 32'h0010_0000, 32'h7, 0);
    endtask

    task automatic tStore();
        storeVal = '{32'h3, 32'h5, 32'h7, 32'h2, 32'h9, 32'h3};
        storeValid = 1'b1;
        doReset();
        storeValid = 1'b0;
        acc(0, MUS_ADDR_POS_NUM, 32'h0, 0, 32'h3);
        acc(0, MUS_ADDR_RMP_DEN, 32'h0, 0, 32'h3);
        cv(MUS_Q_POS, 0, 32'hA, 32'h6, 0);
        cv(MUS_Q_VEL, 0, 32'h4, 32'hE, 0);
        cv(MUS_Q_RMP, 1, 32'h6, 32'h2, 0);
    endtask

    initial begin
        coreClk = 1'b0;
        rstN = 1'b0;
        parWrite = 1'b0;
        parRead = 1'b0;
        parAddr = 16'h0;
        parWdata = 32'h0;
        storeValid = 1'b0;
        storeVal = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        powerStageOn = 1'b0;
        convReq = 1'b0;
        convQty = 2'h0;
        convToUser = 1'b0;
        convIn = 32'h0;
        nFail = 0;
        checkCount = 0;
        cycles = 0;
        doReset();
        tFactory();
        tStage();
        tVelRamp();
        tRefuse();
        tSmall();
        tStore();
        completeRun();
    end
endmodule
